//--- src/starter_fieldbus_regs.svh
// register map, field positions and timing constants of the parameter bank
`ifndef STARTER_FIELDBUS_REGS_SVH
`define STARTER_FIELDBUS_REGS_SVH

// ------------
// logic addresses (one 16-bit word each, 32-bit values take two)
// ------------
`define ADDR_STATE_WORD      16'h0C81
`define ADDR_CURRENT_RMS     16'h0C84
`define ADDR_RUN_SECONDS_LO  16'h0CAC
`define ADDR_RUN_SECONDS_HI  16'h0CAD
`define ADDR_AOUT1_SCALED    16'h148D
`define ADDR_AOUT1_PHYSICAL  16'h1497
`define ADDR_CHANNEL_FLAGS   16'h20FA
`define ADDR_MOTION_CMD      16'h2135
`define ADDR_EXT_CMD         16'h2138
`define ADDR_THERMAL_PCT     16'h259E
`define ADDR_ENERGY_KWH_LO   16'h299C
`define ADDR_ENERGY_KWH_HI   16'h299D

// ------------
// writable bit masks and reset values
// ------------
`define MOTION_CMD_MASK      16'hF88F
`define EXT_CMD_MASK         16'hE00F
`define MOTION_CMD_RESET     16'h0000
`define EXT_CMD_RESET        16'h0000
`define AOUT_RESET           16'h0000
`define WORD_ZERO            16'h0000

// ------------
// command word fields
// ------------
`define CMD_SWITCH_ON        0
`define CMD_ENABLE_VOLTAGE   1
`define CMD_QUICK_STOP_N     2
`define CMD_ENABLE_OP        3
`define CMD_ERROR_RESET      7
`define CMD_FUNC_A           11
`define CMD_FUNC_B           12
`define CMD_BRAKE_STOP       13
`define CMD_DECEL_STOP       14
`define CMD_FUNC_C           15

// ------------
// extended command word fields
// ------------
`define EXT_FACTORY_RESTORE  0
`define EXT_STORE_PARAMS     1
`define EXT_RESTORE_SAVED    2
`define EXT_EXTERNAL_ERROR   3
`define EXT_LOCK_STOPPED     13
`define EXT_LINE_MON_OFF     14
`define EXT_NO_CONSISTENCY   15

// ------------
// timing
// ------------
`define CLK_HZ               20000000
`define RUN_TIME_UNIT_S      1
`define SEC_CYCLES           (`RUN_TIME_UNIT_S * `CLK_HZ)

`endif

//--- src/starter_fieldbus_pkg.sv
// shared types of the fieldbus parameter bank
package starter_fieldbus_pkg;

  typedef logic [15:0] word_t;

  typedef enum logic {
    UNIT_MILLIVOLT,
    UNIT_MICROAMP
  } aout_unit_t;

endpackage

//--- src/rise_detect.sv
// per-bit rising edge detector
`timescale 1ns/1ps

module rise_detect #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels in, one-cycle pulses out
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] prev_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          prev_q[i] <= 1'b0;
        end else begin
          prev_q[i] <= level[i];
        end
      end
      assign rise[i] = level[i] & ~prev_q[i];
    end
  endgenerate

endmodule

//--- src/event_accumulator.sv
// 32-bit accumulator with event divider and per-half preset
`timescale 1ns/1ps

module event_accumulator #(
  parameter int DIV = 1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // events to count, DIV of them make one unit
  input  wire logic        inc_en,
  // software preset of either half
  input  wire logic        load_lo,
  input  wire logic        load_hi,
  input  wire logic [15:0] load_val,
  // running total
  output logic      [31:0] count
);

  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  logic [DW-1:0] div_q;
  logic [DW-1:0] div_d;
  logic [31:0]   count_q;
  logic [31:0]   base;
  logic          tick;

  assign tick  = inc_en && (div_q == DIV_LAST);
  assign div_d = tick ? '0 : (inc_en ? div_q + 1'b1 : div_q);
  // a unit arriving with a preset is added on top, never lost
  assign base  = {load_hi ? load_val : count_q[31:16],
                  load_lo ? load_val : count_q[15:0]};

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q   <= '0;
      count_q <= '0;
    end else begin
      div_q   <= div_d;
      count_q <= base + {31'h0, tick};
    end
  end

  assign count = count_q;

endmodule

//--- src/starter_fieldbus_control_status_regs.sv
// fieldbus parameter bank: monitoring words, command words, analog out
// Operation
// [RULE1] analog output writes ignored while a starter function owns it
// [RULE2] signed physical analog value: millivolts or microamps
// [RULE3] status bits 0,1,2: ready, switched on, operating
// [RULE4] status bits 3,4,7: error, voltage enabled, alarm
// [RULE5] status bit5 low quick stop, 6 no switch-on, 9 low local, 14 key
// [RULE6] current: mean of three fundamental rms lines, 0.1 A
// [RULE7] thermal state in percent, 100 is nominal
// [RULE8] read-only 32-bit energized seconds
// [RULE9] 32-bit energy total in kilowatt-hours
// [RULE10] one flag per active command channel
// [RULE11] command bits 0,1,3: switch on, enable voltage, run
// [RULE12] command bit 2 low means quick stop active
// [RULE13] error reset only on rising edge of command bit 7
// [RULE14] command bits 13,14 default to braking and decelerated stop
// [RULE15] unassigned bit 13 or 14 reverts to its default stop
// [RULE16] command bits 11,12,15 routed to configured functions
// [RULE17] extended bits 0-2 act on edge while unpowered, then clear
// [RULE18] rising edge of extended bit 3 raises an external error
// [RULE19] extended bit 13 locks when stopped, bit 14 line monitor off
// [RULE20] extended bit 15 skips consistency check and locks
// [RULE21] reserved status and control bits read zero, writes ignored
`timescale 1ns/1ps
`include "starter_fieldbus_regs.svh"

module starter_fieldbus_control_status_regs
  import starter_fieldbus_pkg::*;
#(
  parameter int SEC_CYCLES = `SEC_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // parameter access from the fieldbus stack
  input  wire logic [15:0] par_addr,
  input  wire logic        par_rd,
  input  wire logic        par_wr,
  input  wire logic [15:0] par_wdata,
  output logic      [15:0] par_rdata,
  output logic             par_ack,
  output logic             par_err,
  // starter state
  input  wire logic        st_ready,
  input  wire logic        st_switched_on,
  input  wire logic        st_op_enabled,
  input  wire logic        st_error,
  input  wire logic        st_voltage,
  input  wire logic        st_quick_stop,
  input  wire logic        st_switch_on_disabled,
  input  wire logic        st_alarm,
  input  wire logic        st_local,
  input  wire logic        st_stop_key,
  input  wire logic        motor_energized,
  input  wire logic        kwh_pulse,
  // measurements
  input  wire logic [15:0] line_current_a,
  input  wire logic [15:0] line_current_b,
  input  wire logic [15:0] line_current_c,
  input  wire logic [15:0] thermal_pct,
  // active command channels
  input  wire logic        chan_terminal,
  input  wire logic        chan_keypad,
  input  wire logic        chan_modbus,
  input  wire logic        chan_canopen,
  input  wire logic        chan_option,
  input  wire logic        chan_tool_a,
  input  wire logic        chan_tool_b,
  // configuration from the starter
  input  wire logic        aout_assigned,
  input  wire aout_unit_t  aout_unit,
  input  wire logic        brake_bit_reassigned,
  input  wire logic        decel_bit_reassigned,
  // motion command outputs
  output logic             switch_on_req,
  output logic             enable_voltage,
  output logic             quick_stop_active,
  output logic             run_cmd,
  output logic             error_reset_pulse,
  output logic             brake_stop_order,
  output logic             decel_stop_order,
  output logic      [4:0]  func_bits,
  // extended command outputs
  output logic             factory_restore_pulse,
  output logic             store_params_pulse,
  output logic             restore_saved_pulse,
  output logic             ext_error_pulse,
  output logic             lock_when_stopped,
  output logic             line_monitor_off,
  output logic             consistency_skip,
  output logic             validate_all,
  // analog output values
  output logic      [15:0] aout_scaled,
  output logic      [15:0] aout_millivolt,
  output logic      [15:0] aout_microamp
);

  // ------------
  // address decode
  // ------------
  wire hit_state   = par_addr == `ADDR_STATE_WORD;
  wire hit_current = par_addr == `ADDR_CURRENT_RMS;
  wire hit_run_lo  = par_addr == `ADDR_RUN_SECONDS_LO;
  wire hit_run_hi  = par_addr == `ADDR_RUN_SECONDS_HI;
  wire hit_ao_sc   = par_addr == `ADDR_AOUT1_SCALED;
  wire hit_ao_ph   = par_addr == `ADDR_AOUT1_PHYSICAL;
  wire hit_chan    = par_addr == `ADDR_CHANNEL_FLAGS;
  wire hit_cmd     = par_addr == `ADDR_MOTION_CMD;
  wire hit_ext     = par_addr == `ADDR_EXT_CMD;
  wire hit_therm   = par_addr == `ADDR_THERMAL_PCT;
  wire hit_kwh_lo  = par_addr == `ADDR_ENERGY_KWH_LO;
  wire hit_kwh_hi  = par_addr == `ADDR_ENERGY_KWH_HI;

  wire wr_hit = hit_ao_sc | hit_ao_ph | hit_cmd | hit_ext
              | hit_kwh_lo | hit_kwh_hi;
  wire rd_hit = wr_hit | hit_state | hit_current | hit_run_lo
              | hit_run_hi | hit_chan | hit_therm;

  wire wr_cmd    = par_wr & hit_cmd;
  wire wr_ext    = par_wr & hit_ext;
  wire wr_kwh_lo = par_wr & hit_kwh_lo;
  wire wr_kwh_hi = par_wr & hit_kwh_hi;
  // an output owned by a starter function keeps its value
  // [RULE1] analog write gate
  wire wr_ao_sc  = par_wr & hit_ao_sc & ~aout_assigned;
  wire wr_ao_ph  = par_wr & hit_ao_ph & ~aout_assigned;

  // ------------
  // writable words
  // ------------
  word_t cmd_q;
  word_t ext_q;
  word_t ext_d;
  word_t ao_sc_q;
  word_t ao_ph_q;
  logic  [4:0] rise;
  logic  [2:0] ext_take;

  // [RULE21] reserved bits never stored
  wire word_t cmd_d = wr_cmd ? (par_wdata & `MOTION_CMD_MASK) : cmd_q;

  // [RULE17] taken edge clears its bit, fresh write wins
  assign ext_take = rise[2:0] & {3{~motor_energized}};
  always_comb begin
    ext_d = ext_q;
    ext_d[`EXT_RESTORE_SAVED:`EXT_FACTORY_RESTORE] =
      ext_q[`EXT_RESTORE_SAVED:`EXT_FACTORY_RESTORE] & ~ext_take;
    if (wr_ext) begin
      ext_d = par_wdata & `EXT_CMD_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q   <= `MOTION_CMD_RESET;
      ext_q   <= `EXT_CMD_RESET;
      ao_sc_q <= `AOUT_RESET;
      ao_ph_q <= `AOUT_RESET;
    end else begin
      cmd_q   <= cmd_d;
      ext_q   <= ext_d;
      ao_sc_q <= wr_ao_sc ? par_wdata : ao_sc_q;
      ao_ph_q <= wr_ao_ph ? par_wdata : ao_ph_q;
    end
  end

  // ------------
  // edge detection on command bits
  // ------------
  // a held high level gives one pulse only
  rise_detect #(
    .W (5)
  ) u_rise (
    .clk   (clk),
    .rst   (rst),
    .level ({cmd_q[`CMD_ERROR_RESET],
             ext_q[`EXT_EXTERNAL_ERROR:`EXT_FACTORY_RESTORE]}),
    .rise  (rise)
  );

  logic err_rst_q;
  logic ext_err_q;
  logic [2:0] take_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      err_rst_q <= 1'b0;
      ext_err_q <= 1'b0;
      take_q    <= 3'h0;
    end else begin
      // [RULE13] reset pulse on edge of bit 7
      err_rst_q <= rise[4];
      // [RULE18] external error on edge of bit 3
      ext_err_q <= rise[3];
      take_q    <= ext_take;
    end
  end

  // ------------
  // command decode
  // ------------
  // [RULE11] switch on, voltage, run
  assign switch_on_req     = cmd_q[`CMD_SWITCH_ON];
  assign enable_voltage    = cmd_q[`CMD_ENABLE_VOLTAGE];
  assign run_cmd           = cmd_q[`CMD_ENABLE_OP];
  // [RULE12] active-low quick stop
  assign quick_stop_active = ~cmd_q[`CMD_QUICK_STOP_N];
  assign error_reset_pulse = err_rst_q;
  // [RULE14] default stop orders
  // [RULE15] revert when no function assigned
  assign brake_stop_order  = cmd_q[`CMD_BRAKE_STOP] & ~brake_bit_reassigned;
  assign decel_stop_order  = cmd_q[`CMD_DECEL_STOP] & ~decel_bit_reassigned;
  // [RULE16] route configurable bits
  assign func_bits = {cmd_q[`CMD_FUNC_C],
                      cmd_q[`CMD_DECEL_STOP] & decel_bit_reassigned,
                      cmd_q[`CMD_BRAKE_STOP] & brake_bit_reassigned,
                      cmd_q[`CMD_FUNC_B],
                      cmd_q[`CMD_FUNC_A]};

  assign factory_restore_pulse = take_q[0];
  assign store_params_pulse    = take_q[1];
  assign restore_saved_pulse   = take_q[2];
  assign ext_error_pulse       = ext_err_q;
  // [RULE19] lock and line monitor
  assign lock_when_stopped = ext_q[`EXT_LOCK_STOPPED]
                           | ext_q[`EXT_NO_CONSISTENCY];
  assign line_monitor_off  = ext_q[`EXT_LINE_MON_OFF];
  // [RULE20] consistency check selection
  assign consistency_skip  = ext_q[`EXT_NO_CONSISTENCY];
  assign validate_all      = ~ext_q[`EXT_NO_CONSISTENCY];

  // ------------
  // analog output
  // ------------
  assign aout_scaled = ao_sc_q;
  // [RULE2] unit follows output type
  assign aout_millivolt = (aout_unit == UNIT_MILLIVOLT) ? ao_ph_q
                                                        : `WORD_ZERO;
  assign aout_microamp  = (aout_unit == UNIT_MICROAMP) ? ao_ph_q
                                                       : `WORD_ZERO;

  // ------------
  // monitoring words
  // ------------
  word_t state_q;
  word_t current_q;
  word_t chan_q;
  word_t therm_q;
  logic [17:0] cur_sum;
  logic [17:0] cur_avg;

  // [RULE6] three-phase average, 0.1 A units kept
  assign cur_sum = {2'b00, line_current_a} + {2'b00, line_current_b}
                 + {2'b00, line_current_c};
  assign cur_avg = cur_sum / 18'd3;

  // [RULE3] [RULE4] [RULE5] status word assembly
  wire word_t state_d = {1'b0, st_stop_key, 4'h0, ~st_local, 1'b0,
                         st_alarm, st_switch_on_disabled, ~st_quick_stop,
                         st_voltage, st_error, st_op_enabled,
                         st_switched_on, st_ready};
  // [RULE10] channel flags
  wire word_t chan_d = {chan_tool_b, chan_tool_a, 4'h0, chan_option,
                        2'b00, chan_canopen, 2'b00, chan_modbus,
                        chan_keypad, 1'b0, chan_terminal};

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= `WORD_ZERO;
      current_q <= `WORD_ZERO;
      chan_q    <= `WORD_ZERO;
      therm_q   <= `WORD_ZERO;
    end else begin
      state_q   <= state_d;
      current_q <= cur_avg[15:0];
      chan_q    <= chan_d;
      // [RULE7] percent passed through
      therm_q   <= thermal_pct;
    end
  end

  // ------------
  // run time and energy totals
  // ------------
  logic [31:0] run_s;
  logic [31:0] kwh;

  // [RULE8] seconds while energized, no write path
  event_accumulator #(
    .DIV (SEC_CYCLES)
  ) u_run (
    .clk      (clk),
    .rst      (rst),
    .inc_en   (motor_energized),
    .load_lo  (1'b0),
    .load_hi  (1'b0),
    .load_val (`WORD_ZERO),
    .count    (run_s)
  );

  // [RULE9] one count per kilowatt-hour pulse
  event_accumulator #(
    .DIV (1)
  ) u_kwh (
    .clk      (clk),
    .rst      (rst),
    .inc_en   (kwh_pulse),
    .load_lo  (wr_kwh_lo),
    .load_hi  (wr_kwh_hi),
    .load_val (par_wdata),
    .count    (kwh)
  );

  // ------------
  // read mux and answer
  // ------------
  word_t rmux;
  word_t rdata_q;
  logic  ack_q;
  logic  err_q;

  always_comb begin
    rmux = `WORD_ZERO;
    case (1'b1)
      hit_state:   rmux = state_q;
      hit_current: rmux = current_q;
      hit_run_lo:  rmux = run_s[15:0];
      hit_run_hi:  rmux = run_s[31:16];
      hit_ao_sc:   rmux = ao_sc_q;
      hit_ao_ph:   rmux = ao_ph_q;
      hit_chan:    rmux = chan_q;
      hit_cmd:     rmux = cmd_q;
      hit_ext:     rmux = ext_q;
      hit_therm:   rmux = therm_q;
      hit_kwh_lo:  rmux = kwh[15:0];
      hit_kwh_hi:  rmux = kwh[31:16];
      default:     rmux = `WORD_ZERO;
    endcase
  end

  // writes to read-only addresses and any access to unknown ones answer with an error flag
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= `WORD_ZERO;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= (par_rd && rd_hit) ? rmux : rdata_q;
      ack_q   <= par_rd | par_wr;
      err_q   <= (par_rd & ~rd_hit) | (par_wr & ~wr_hit);
    end
  end

  assign par_rdata = rdata_q;
  assign par_ack   = ack_q;
  assign par_err   = err_q;

endmodule

//--- dv/sfb_regs_asserts.sv
// concurrent checks on the parameter bank ports
`timescale 1ns/1ps
`include "starter_fieldbus_regs.svh"

module sfb_regs_chk
  import starter_fieldbus_pkg::*;
#(
  parameter int SEC_CYCLES = 10
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // parameter access
  input wire logic [15:0] par_addr,
  input wire logic        par_wr,
  input wire logic [15:0] par_wdata,
  input wire logic        par_ack,
  input wire logic        par_err,
  // starter side
  input wire logic        motor_energized,
  input wire logic        aout_assigned,
  input wire logic        brake_bit_reassigned,
  input wire logic [15:0] aout_scaled,
  // command outputs
  input wire logic        quick_stop_active,
  input wire logic        run_cmd,
  input wire logic        error_reset_pulse,
  input wire logic        brake_stop_order,
  input wire logic        factory_restore_pulse,
  input wire logic        ext_error_pulse,
  input wire logic        lock_when_stopped,
  input wire logic        consistency_skip,
  input wire logic        validate_all
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ------------
  // request shapes
  // ------------
  sequence s_cmd_wr;
    par_wr && par_addr == `ADDR_MOTION_CMD;
  endsequence
  sequence s_ro_wr;
    par_wr && par_addr == `ADDR_RUN_SECONDS_LO;
  endsequence

  a_ro_write_err: assert property (s_ro_wr |=> par_ack && par_err)
    else $error("write to run seconds not refused");
  a_run_follows: assert property (
    s_cmd_wr |=> run_cmd == $past(par_wdata[3]))
    else $error("run command does not follow bit 3");
  a_quick_stop_low: assert property (
    s_cmd_wr |=> quick_stop_active != $past(par_wdata[2]))
    else $error("quick stop not active low");
  a_err_reset_src: assert property (error_reset_pulse |->
    $past(par_wr && par_addr == `ADDR_MOTION_CMD && par_wdata[7], 2))
    else $error("error reset pulse without a write of bit 7");
  a_err_reset_once: assert property (
    error_reset_pulse |=> !error_reset_pulse)
    else $error("error reset pulse longer than one cycle");
  a_ext_err_src: assert property (ext_error_pulse |->
    $past(par_wr && par_addr == `ADDR_EXT_CMD && par_wdata[3], 2))
    else $error("external error pulse without a write of bit 3");
  a_restore_unpow: assert property (
    factory_restore_pulse |-> !$past(motor_energized))
    else $error("factory restore while motor energized");
  a_brake_default: assert property (
    brake_stop_order |-> !brake_bit_reassigned)
    else $error("braking stop while bit reassigned");
  a_skip_locks: assert property (
    consistency_skip |-> lock_when_stopped && !validate_all)
    else $error("consistency skip without lock");
  a_aout_locked: assert property (aout_assigned && par_wr &&
    par_addr == `ADDR_AOUT1_SCALED |=> $stable(aout_scaled))
    else $error("owned analog output took a write");
endmodule

bind starter_fieldbus_control_status_regs sfb_regs_chk #(
  .SEC_CYCLES(SEC_CYCLES)
) u_chk (
  .clk, .rst, .par_addr, .par_wr, .par_wdata, .par_ack,
  .par_err, .motor_energized, .aout_assigned, .brake_bit_reassigned,
  .aout_scaled, .quick_stop_active, .run_cmd, .error_reset_pulse,
  .brake_stop_order, .factory_restore_pulse, .ext_error_pulse,
  .lock_when_stopped, .consistency_skip, .validate_all
);

//--- dv/fieldbus_master_model.sv
// fieldbus master model: one request at a time on the parameter port
`timescale 1ns/1ps

module fieldbus_master (
  // clock
  input  wire logic        clk,
  // request side
  output logic      [15:0] par_addr,
  output logic             par_rd,
  output logic             par_wr,
  output logic      [15:0] par_wdata,
  // answer side
  input  wire logic [15:0] par_rdata,
  input  wire logic        par_ack,
  input  wire logic        par_err
);
  initial begin
    par_addr = 16'h0000;
    par_rd = 1'b0;
    par_wr = 1'b0;
    par_wdata = 16'h0000;
  end

  // request lasts one cycle; idle lines show the inverse, not stale data
  task automatic xfer(input logic w, input logic [15:0] a, d,
                      output logic [15:0] q, output logic e, ok);
    ok = 1'b0;
    q = 16'h0000;
    e = 1'b0;
    @(posedge clk);
    par_addr <= a;
    par_wdata <= d;
    par_rd <= !w;
    par_wr <= w;
    @(posedge clk);
    par_rd <= 1'b0;
    par_wr <= 1'b0;
    par_addr <= ~a;
    par_wdata <= ~d;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk);
      if (par_ack === 1'b1) begin
        ok = 1'b1;
        q = par_rdata;
        e = par_err;
      end
    end
  endtask
endmodule

//--- dv/tb_top.sv
// self-checking bench for the fieldbus parameter bank
`timescale 1ns/1ps
`include "starter_fieldbus_regs.svh"

module tb_top
  import starter_fieldbus_pkg::*;
;
  // short divider keeps the run-time count quick
  localparam int          SEC = 10;
  localparam logic [15:0] CMD = `ADDR_MOTION_CMD;
  localparam logic [15:0] EXT = `ADDR_EXT_CMD;
  typedef struct packed {
    logic [15:0] wd;
    logic [1:0]  re;
    logic [10:0] o;
  } row_t;
  row_t rows [6] = '{'{16'h000B, 2'b00, 11'h780}, '{16'h0004, 2'b00, 11'h000},
    '{16'h6000, 2'b00, 11'h160}, '{16'h6000, 2'b11, 11'h10C},
    '{16'hFFFF, 2'b00, 11'h6F3}, '{16'h9800, 2'b10, 11'h113}};
  logic [9:0]  pats [3] = '{10'h3FF, 10'h000, 10'h2A5};
  logic        clk = 1'b0, rst = 1'b1, e, ok, kwh_pulse = 1'b0;
  logic        motor_energized = 1'b0, aout_assigned = 1'b0;
  logic        brake_bit_reassigned = 1'b0, decel_bit_reassigned = 1'b0;
  logic [9:0]  st_v = 10'h000, p;
  logic [6:0]  ch_v = 7'h00;
  logic [15:0] line_current_a = 16'h0000, line_current_b = 16'h0000;
  logic [15:0] line_current_c = 16'h0000, thermal_pct = 16'h0000;
  aout_unit_t  aout_unit = UNIT_MILLIVOLT;
  logic [15:0] par_addr, par_wdata, par_rdata, q, aout_scaled;
  logic [15:0] aout_millivolt, aout_microamp;
  logic        par_rd, par_wr, par_ack, par_err, switch_on_req, run_cmd;
  logic        enable_voltage, quick_stop_active, error_reset_pulse;
  logic        brake_stop_order, decel_stop_order, factory_restore_pulse;
  logic        store_params_pulse, restore_saved_pulse, ext_error_pulse;
  logic        lock_when_stopped, line_monitor_off, consistency_skip;
  logic        validate_all;
  logic [4:0]  func_bits;
  int          n_errors = 0, n_tests = 0, n_erst = 0, n_cfg = 0;
  int          n_xerr = 0, n0;
  wire [10:0] cmd_o = {switch_on_req, enable_voltage, quick_stop_active,
    run_cmd, brake_stop_order, decel_stop_order, func_bits};
  wire [3:0]  ext_o = {lock_when_stopped, line_monitor_off,
    consistency_skip, validate_all};

  always #25 clk = ~clk;
  always @(posedge clk) begin
    n_erst <= n_erst + int'(error_reset_pulse === 1'b1);
    n_xerr <= n_xerr + int'(ext_error_pulse === 1'b1);
    n_cfg <= n_cfg + int'(factory_restore_pulse === 1'b1)
      + int'(store_params_pulse === 1'b1) + int'(restore_saved_pulse === 1'b1);
  end

  fieldbus_master u_m (.clk, .par_addr, .par_rd, .par_wr, .par_wdata,
    .par_rdata, .par_ack, .par_err);
  starter_fieldbus_control_status_regs #(.SEC_CYCLES(SEC)) dut (
    .clk, .rst, .par_addr, .par_rd, .par_wr, .par_wdata, .par_rdata,
    .par_ack, .par_err, .st_ready(st_v[0]), .st_switched_on(st_v[1]),
    .st_op_enabled(st_v[2]), .st_error(st_v[3]), .st_voltage(st_v[4]),
    .st_quick_stop(st_v[5]), .st_switch_on_disabled(st_v[6]),
    .st_alarm(st_v[7]), .st_local(st_v[8]), .st_stop_key(st_v[9]),
    .motor_energized, .kwh_pulse, .line_current_a, .line_current_b,
    .line_current_c, .thermal_pct, .chan_terminal(ch_v[0]),
    .chan_keypad(ch_v[1]), .chan_modbus(ch_v[2]), .chan_canopen(ch_v[3]),
    .chan_option(ch_v[4]), .chan_tool_a(ch_v[5]), .chan_tool_b(ch_v[6]),
    .aout_assigned, .aout_unit, .brake_bit_reassigned,
    .decel_bit_reassigned, .switch_on_req, .enable_voltage,
    .quick_stop_active, .run_cmd, .error_reset_pulse, .brake_stop_order,
    .decel_stop_order, .func_bits, .factory_restore_pulse,
    .store_params_pulse, .restore_saved_pulse, .ext_error_pulse,
    .lock_when_stopped, .line_monitor_off, .consistency_skip,
    .validate_all, .aout_scaled, .aout_millivolt, .aout_microamp);

  // ------------
  // checking and bus helpers
  // ------------
  task automatic results();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] x, g);
    n_tests++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, d);
    u_m.xfer(w, a, d, q, e, ok);
    if (ok !== 1'b1) begin
      chk("bus_ack", 16'h0001, 16'h0000);
      results();
    end
  endtask
  task automatic wr(input logic [15:0] a, d, input logic ee);
    bus(1'b1, a, d);
    chk("wr_err", {15'h0000, ee}, {15'h0000, e});
  endtask
  task automatic rd(input string nm, input logic [15:0] a, x);
    bus(1'b0, a, 16'h0000);
    chk(nm, x, q);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    tick(6);
    rst <= 1'b0;
    @(negedge clk);
    chk("rst_flags", 16'h0003, {14'h0, cmd_o[8], ext_o[0]});
    foreach (rows[i]) begin
      @(posedge clk);
      {brake_bit_reassigned, decel_bit_reassigned} <= rows[i].re;
      wr(CMD, rows[i].wd, 1'b0);
      chk("cmd_outs", {5'h00, rows[i].o}, {5'h00, cmd_o});
      rd("cmd_rb", CMD, rows[i].wd & `MOTION_CMD_MASK);
    end
    foreach (pats[i]) begin
      @(posedge clk);
      p = pats[i];
      st_v <= p;
      ch_v <= p[6:0];
      rd("status", `ADDR_STATE_WORD,
         {1'b0, p[9], 4'h0, ~p[8], 1'b0, p[7:6], ~p[5], p[4:0]});
      rd("channels", `ADDR_CHANNEL_FLAGS,
         {p[6:5], 4'h0, p[4], 2'b00, p[3], 2'b00, p[2:1], 1'b0, p[0]});
    end
    @(posedge clk);
    {line_current_a, line_current_b} <= {16'h000A, 16'h0014};
    {line_current_c, thermal_pct} <= {16'h001F, 16'h0064};
    rd("current", `ADDR_CURRENT_RMS, 16'h0014);
    rd("thermal", `ADDR_THERMAL_PCT, 16'h0064);
    @(posedge clk);
    motor_energized <= 1'b1;
    tick(3 * SEC + 5);
    rd("run_lo", `ADDR_RUN_SECONDS_LO, 16'h0003);
    rd("run_hi", `ADDR_RUN_SECONDS_HI, 16'h0000);
    wr(`ADDR_RUN_SECONDS_LO, 16'h00FF, 1'b1);
    bus(1'b0, 16'h1234, 16'h0000);
    chk("unmapped", 16'h0001, {15'h0000, e});
    n0 = n_cfg;
    wr(EXT, 16'h0001, 1'b0);
    tick(3);
    chk("cfg_blocked", 16'h0000, 16'(n_cfg - n0));
    rd("ext_held", EXT, 16'h0001);
    @(posedge clk);
    motor_energized <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      wr(EXT, 16'h0000, 1'b0);
      wr(EXT, 16'h0001 << k, 1'b0);
    end
    tick(3);
    chk("cfg_pulses", 16'h0003, 16'(n_cfg - n0));
    rd("ext_cleared", EXT, 16'h0000);
    n0 = n_xerr;
    wr(EXT, 16'h0008, 1'b0);
    wr(EXT, 16'h0008, 1'b0);
    tick(3);
    chk("ext_err", 16'h0001, 16'(n_xerr - n0));
    wr(EXT, 16'hFFF0, 1'b0);
    chk("ext_hi", 16'h000E, {12'h000, ext_o});
    rd("ext_rb", EXT, 16'hE000);
    wr(EXT, 16'h2000, 1'b0);
    chk("ext_lock", 16'h0009, {12'h000, ext_o});
    n0 = n_erst;
    wr(CMD, 16'h0080, 1'b0);
    wr(CMD, 16'h0080, 1'b0);
    wr(CMD, 16'h0000, 1'b0);
    wr(CMD, 16'h0080, 1'b0);
    tick(3);
    chk("err_reset", 16'h0002, 16'(n_erst - n0));
    repeat (3) begin
      @(posedge clk);
      kwh_pulse <= 1'b1;
      @(posedge clk);
      kwh_pulse <= 1'b0;
    end
    rd("kwh_lo", `ADDR_ENERGY_KWH_LO, 16'h0003);
    wr(`ADDR_ENERGY_KWH_HI, 16'h0001, 1'b0);
    rd("kwh_hi", `ADDR_ENERGY_KWH_HI, 16'h0001);
    wr(`ADDR_AOUT1_PHYSICAL, 16'h8001, 1'b0);
    tick(1);
    @(negedge clk);
    chk("aout_mv", 16'h8001, aout_millivolt);
    chk("aout_ua0", 16'h0000, aout_microamp);
    tick(1);
    aout_unit <= UNIT_MICROAMP;
    tick(1);
    @(negedge clk);
    chk("aout_ua", 16'h8001, aout_microamp);
    wr(`ADDR_AOUT1_SCALED, 16'h0123, 1'b0);
    @(posedge clk);
    aout_assigned <= 1'b1;
    wr(`ADDR_AOUT1_SCALED, 16'h0456, 1'b0);
    chk("aout_owned", 16'h0123, aout_scaled);
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    rd("rst_cmd", CMD, 16'h0000);
    rd("rst_run", `ADDR_RUN_SECONDS_LO, 16'h0000);
    results();
  end
endmodule
